// *** qso_defines.svh ***
// register offsets, field positions, reset values and pattern constants of the quad serial output block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef QSO_DEFINES_SVH
`define QSO_DEFINES_SVH

// register offsets
`define QSO_ADDR_TEST_MODE      8'h0d
`define QSO_ADDR_OUTPUT_MODE    8'h14
`define QSO_ADDR_OUTPUT_ADJUST  8'h15
`define QSO_ADDR_SERIAL_CTRL    8'h21
`define QSO_ADDR_STATUS         8'h22
`define QSO_ADDR_USER1_LO       8'h19
`define QSO_ADDR_USER1_HI       8'h1a
`define QSO_ADDR_USER2_LO       8'h1b
`define QSO_ADDR_USER2_HI       8'h1c

// field positions
`define QSO_BIT_TWOS_COMP       0
`define QSO_BIT_INVERT          2
`define QSO_BIT_LOW_SWING       3
`define QSO_BIT_TERM_BOOST      0
`define QSO_BIT_LSB_FIRST       7
`define QSO_BIT_LOW_RATE_PLL    3
`define QSO_LSB_RES             0
`define QSO_MSB_RES             1

// reset values
`define QSO_RST_TEST_MODE       4'h0
`define QSO_RST_RES             2'h0
`define QSO_RST_USER            8'h00
`define QSO_RST_WORD_LEN        5'h0a

// pattern words: mixed-frequency words right aligned, checker and midscale 16 bits left aligned
`define QSO_MIX8                14'h00a3
`define QSO_MIX10               14'h0263
`define QSO_MIX12               14'h0a33
`define QSO_MIX14               14'h2867
`define QSO_CHECKER             16'haaaa
`define QSO_MIDSCALE            16'h8000

// pseudorandom seeds
`define QSO_PN9_SEED            9'h0df
`define QSO_PN23_SEED           23'h0a6e02

// timing: strap settle cycles after reset release
`define QSO_STRAP_WAIT          2'h3

`endif

// *** qso_pkg.sv ***
// types shared by the quad serial output block
package qso_pkg;

   typedef enum logic [3:0] {
      QSO_TM_OFF        = 4'b0000,
      QSO_TM_MIDSCALE   = 4'b0001,
      QSO_TM_FULL_POS   = 4'b0010,
      QSO_TM_FULL_NEG   = 4'b0011,
      QSO_TM_CHECKER    = 4'b0100,
      QSO_TM_PN_LONG    = 4'b0101,
      QSO_TM_PN_SHORT   = 4'b0110,
      QSO_TM_WORD_TGL   = 4'b0111,
      QSO_TM_USER       = 4'b1000,
      QSO_TM_BIT_TGL    = 4'b1001,
      QSO_TM_SYNC       = 4'b1010,
      QSO_TM_ONE_HIGH   = 4'b1011,
      QSO_TM_MIXED      = 4'b1100
   } qso_test_e;

   typedef enum logic [1:0] {
      QSO_RES_10 = 2'b00,
      QSO_RES_8  = 2'b01,
      QSO_RES_12 = 2'b10,
      QSO_RES_14 = 2'b11
   } qso_res_e;

   typedef logic [15:0] qso_word_t;

endpackage : qso_pkg

// *** qso_rx_model.sv ***
// receiver model: double-edge capture and frame-based word assembly
`timescale 1ns/1ps
`default_nettype none
module qso_rx_model #(
   parameter int NUM_LANES = 4
) (
   // link from the block
   input wire logic                 bit_clock_out,
   input wire logic                 word_frame_clock_out,
   input wire logic [NUM_LANES-1:0] lane_data,
   // assembled words, right aligned, first bit highest
   output logic [NUM_LANES-1:0][15:0] rx_word,
   output int                         rx_bits,
   output int                         rx_count
);
   logic [NUM_LANES-1:0][15:0] shift_q;
   int                         bit_cnt;
   logic                       frame_q;

   initial begin
      rx_word = '0;
      rx_bits = 0;
      rx_count = 0;
      shift_q = '0;
      bit_cnt = 0;
      frame_q = 1'b0;
   end

   // both edges, frame rise opens a word
   always @(bit_clock_out) begin
      if (word_frame_clock_out && !frame_q) begin
         rx_word = shift_q;
         rx_bits = bit_cnt;
         rx_count++;
         bit_cnt = 0;
         shift_q = '0;
      end
      for (int i = 0; i < NUM_LANES; i++) begin
         shift_q[i] = {shift_q[i][14:0], lane_data[i]};
      end
      bit_cnt++;
      frame_q = word_frame_clock_out;
   end
endmodule : qso_rx_model
`default_nettype wire

// *** qso_serial_out.sv ***
// quad converter serial output: coding, test patterns, serializer, frame and bit clocks
`timescale 1ns/1ps
`default_nettype none
`include "qso_defines.svh"

module qso_serial_out
   import qso_pkg::*;
#(
   parameter int NUM_LANES = 4
) (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          reset_n,
   // converter samples, offset binary
   input  wire logic [NUM_LANES-1:0][9:0]     sample_data,
   // configuration port
   input  wire logic                          cfg_write,
   input  wire logic [7:0]                    cfg_addr,
   input  wire logic [7:0]                    cfg_wdata,
   output logic      [7:0]                    cfg_rdata,
   // mode strap
   input  wire logic                          drive_mode_strap_pin,
   // serial link
   output logic      [NUM_LANES-1:0]          lane_data,
   output logic                               bit_clock_out,
   output logic                               word_frame_clock_out,
   // driver and pll controls
   output logic                               low_swing_mode,
   output logic                               termination_boost,
   output logic                               low_rate_pll_en
);

   if (NUM_LANES < 1 || NUM_LANES > 8) begin : g_lane_check
      $error("NUM_LANES out of range");
   end

   // ---------------------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------------------

   // data bits per word
   function automatic logic [4:0] fn_width(input qso_res_e res);
      unique case (res)
         QSO_RES_8:  fn_width = 5'd8;
         QSO_RES_10: fn_width = 5'd10;
         QSO_RES_12: fn_width = 5'd12;
         QSO_RES_14: fn_width = 5'd14;
      endcase
   endfunction : fn_width

   // serial bits per word, 12-bit stretched to 14
   function automatic logic [4:0] fn_length(input qso_res_e res);
      fn_length = (res == QSO_RES_12) ? 5'd14 : fn_width(res);
   endfunction : fn_length

   // move a right-aligned word to the top of 16 bits
   function automatic qso_word_t fn_left(input logic [13:0] val, input logic [4:0] w);
      fn_left = qso_word_t'({2'b00, val} << (5'd16 - w));
   endfunction : fn_left

   // fixed pattern word, left aligned; bit 16 marks data-format subject
   function automatic logic [16:0] fn_pattern(input qso_test_e mode, input logic sel,
                                               input qso_res_e res, input qso_word_t u1,
                                               input qso_word_t u2);
      logic [4:0] w;
      logic [13:0] mix;
      w   = fn_width(res);
      mix = `QSO_MIX10;
      unique case (res)
         QSO_RES_8:  mix = `QSO_MIX8;
         QSO_RES_10: mix = `QSO_MIX10;
         QSO_RES_12: mix = `QSO_MIX12;
         QSO_RES_14: mix = `QSO_MIX14;
      endcase
      unique case (mode)
         QSO_TM_MIDSCALE: fn_pattern = {1'b1, `QSO_MIDSCALE};
         QSO_TM_FULL_POS: fn_pattern = {1'b1, 16'hffff};
         QSO_TM_FULL_NEG: fn_pattern = {1'b1, 16'h0000};
         QSO_TM_CHECKER:  fn_pattern = {1'b0, sel ? ~`QSO_CHECKER : `QSO_CHECKER};
         QSO_TM_WORD_TGL: fn_pattern = {1'b0, sel ? 16'h0000 : 16'hffff};
         QSO_TM_USER:     fn_pattern = {1'b0, sel ? u2 : u1};
         QSO_TM_BIT_TGL:  fn_pattern = {1'b0, `QSO_CHECKER};
         QSO_TM_SYNC:     fn_pattern = {1'b0, fn_left(14'(16'hffff >> (5'd16 - (w >> 1))), w)};
         // one bit high and mixed frequency
         QSO_TM_ONE_HIGH: fn_pattern = {1'b0, `QSO_MIDSCALE};
         QSO_TM_MIXED:    fn_pattern = {1'b0, fn_left(mix, w)};
         default:         fn_pattern = {1'b1, 16'h0000};
      endcase
   endfunction : fn_pattern

   // short sequence, ten steps, top stage after shift is the output; returns {word, state}
   function automatic logic [18:0] fn_pn9(input logic [8:0] s_in);
      logic [8:0] s;
      logic [9:0] w;
      logic       fb;
      s = s_in;
      w = 10'h000;
      for (int i = 0; i < 10; i++) begin
         fb = s[8] ^ s[4];
         s  = {s[7:0], fb};
         w  = {w[8:0], s[8]};
      end
      fn_pn9 = {w, s};
   endfunction : fn_pn9

   // long sequence, ten steps, inverted output; returns {word, state}
   function automatic logic [32:0] fn_pn23(input logic [22:0] s_in);
      logic [22:0] s;
      logic [9:0]  w;
      logic        fb;
      s = s_in;
      w = 10'h000;
      for (int i = 0; i < 10; i++) begin
         fb = s[22] ^ s[17];
         s  = {s[21:0], fb};
         w  = {w[8:0], ~s[22]};
      end
      fn_pn23 = {w, s};
   endfunction : fn_pn23

   // ---------------------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------------------
   qso_test_e        test_mode;
   qso_res_e         res;
   logic             twos_comp;
   logic             out_invert;
   logic             lsb_first;
   logic             low_swing_cfg;
   logic             term_cfg;
   logic             low_rate_cfg;
   logic [7:0]       user1_lo;
   logic [7:0]       user1_hi;
   logic [7:0]       user2_lo;
   logic [7:0]       user2_hi;
   logic             word_sel;
   logic             strap_low;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         twos_comp     <= 1'b0;
         out_invert    <= 1'b0;
         low_swing_cfg <= 1'b0;
         term_cfg      <= 1'b0;
         lsb_first     <= 1'b0;
         low_rate_cfg  <= 1'b0;
         res           <= qso_res_e'(`QSO_RST_RES);
         test_mode     <= qso_test_e'(`QSO_RST_TEST_MODE);
         user1_lo      <= `QSO_RST_USER;
         user1_hi      <= `QSO_RST_USER;
         user2_lo      <= `QSO_RST_USER;
         user2_hi      <= `QSO_RST_USER;
      end else if (cfg_write) begin
         unique case (cfg_addr)
            `QSO_ADDR_TEST_MODE: test_mode <= qso_test_e'(cfg_wdata[3:0]);
            `QSO_ADDR_OUTPUT_MODE: begin
               twos_comp     <= cfg_wdata[`QSO_BIT_TWOS_COMP];
               out_invert    <= cfg_wdata[`QSO_BIT_INVERT];
               low_swing_cfg <= cfg_wdata[`QSO_BIT_LOW_SWING];
            end
            `QSO_ADDR_OUTPUT_ADJUST: term_cfg <= cfg_wdata[`QSO_BIT_TERM_BOOST];
            `QSO_ADDR_SERIAL_CTRL: begin
               lsb_first    <= cfg_wdata[`QSO_BIT_LSB_FIRST];
               low_rate_cfg <= cfg_wdata[`QSO_BIT_LOW_RATE_PLL];
               res          <= qso_res_e'(cfg_wdata[`QSO_MSB_RES:`QSO_LSB_RES]);
            end
            `QSO_ADDR_USER1_LO: user1_lo <= cfg_wdata;
            `QSO_ADDR_USER1_HI: user1_hi <= cfg_wdata;
            `QSO_ADDR_USER2_LO: user2_lo <= cfg_wdata;
            `QSO_ADDR_USER2_HI: user2_hi <= cfg_wdata;
            default: ;
         endcase
      end
   end

   // register readback, one cycle after the address
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cfg_rdata <= 8'h00;
      end else begin
         unique case (cfg_addr)
            `QSO_ADDR_TEST_MODE:     cfg_rdata <= {4'h0, test_mode};
            `QSO_ADDR_OUTPUT_MODE:   cfg_rdata <= 8'({low_swing_cfg, out_invert, 1'b0, twos_comp});
            `QSO_ADDR_OUTPUT_ADJUST: cfg_rdata <= {7'h00, term_cfg};
            `QSO_ADDR_SERIAL_CTRL:   cfg_rdata <= {lsb_first, 3'h0, low_rate_cfg, 1'b0, res};
            `QSO_ADDR_STATUS:        cfg_rdata <= {5'h00, low_swing_mode, word_sel, strap_low};
            `QSO_ADDR_USER1_LO:      cfg_rdata <= user1_lo;
            `QSO_ADDR_USER1_HI:      cfg_rdata <= user1_hi;
            `QSO_ADDR_USER2_LO:      cfg_rdata <= user2_lo;
            `QSO_ADDR_USER2_HI:      cfg_rdata <= user2_hi;
            default:                 cfg_rdata <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------------------
   // mode strap, synchronised and caught after reset release
   // ---------------------------------------------------------------------------
   logic       strap_meta;
   logic       strap_sync;
   logic [1:0] strap_wait;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
      end else begin
         strap_meta <= drive_mode_strap_pin;
         strap_sync <= strap_meta;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         strap_wait <= 2'h0;
         strap_low  <= 1'b0;
      end else if (strap_wait != `QSO_STRAP_WAIT) begin
         strap_wait <= strap_wait + 2'h1;
         if (strap_wait == `QSO_STRAP_WAIT - 2'h1) begin
            strap_low <= strap_sync;
         end
      end
   end

   // driver and pll controls
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         low_swing_mode    <= 1'b0;
         termination_boost <= 1'b0;
         low_rate_pll_en   <= 1'b0;
      end else begin
         low_swing_mode    <= strap_low | low_swing_cfg;
         termination_boost <= term_cfg;
         low_rate_pll_en   <= low_rate_cfg;
      end
   end

   // ---------------------------------------------------------------------------
   // bit timing: two clocks per serial bit
   // ---------------------------------------------------------------------------
   logic       half;
   logic [4:0] bit_cnt;
   logic [4:0] word_len;
   logic       word_end;

   assign word_end = half && (bit_cnt >= word_len - 5'd1);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         half     <= 1'b0;
         bit_cnt  <= 5'd0;
         word_len <= `QSO_RST_WORD_LEN;
      end else begin
         half <= ~half;
         if (half) begin
            bit_cnt <= word_end ? 5'd0 : bit_cnt + 5'd1;
         end
         // length held per word, no mid-word frame glitch
         if (word_end) begin
            word_len <= fn_length(res);
         end
      end
   end

   // ---------------------------------------------------------------------------
   // word sources
   // ---------------------------------------------------------------------------
   logic [8:0]  pn9;
   logic [22:0] pn23;
   logic [9:0]  pn_word;
   logic [18:0] pn9_next;
   logic [32:0] pn23_next;

   assign pn9_next  = fn_pn9(pn9);
   assign pn23_next = fn_pn23(pn23);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pn9      <= `QSO_PN9_SEED;
         pn23     <= `QSO_PN23_SEED;
         pn_word  <= 10'h000;
         word_sel <= 1'b0;
      end else if (cfg_write && cfg_addr == `QSO_ADDR_TEST_MODE) begin
         // restart sequences and alternation on a mode change
         pn9      <= `QSO_PN9_SEED;
         pn23     <= `QSO_PN23_SEED;
         word_sel <= 1'b0;
      end else if (word_end) begin
         word_sel <= ~word_sel;
         if (test_mode == QSO_TM_PN_SHORT) begin
            pn_word <= pn9_next[18:9];
            pn9     <= pn9_next[8:0];
         end
         if (test_mode == QSO_TM_PN_LONG) begin
            pn_word <= pn23_next[32:23];
            pn23    <= pn23_next[22:0];
         end
      end
   end

   // ---------------------------------------------------------------------------
   // per-lane word load and serializer
   // ---------------------------------------------------------------------------
   logic [16:0] pat;
   logic [4:0]  width;
   logic        lsb_word;
   logic [4:0]  sel_idx;

   assign pat   = fn_pattern(test_mode, word_sel, res, {user1_lo, user1_hi}, {user2_lo, user2_hi});

   // width and order held per word
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         width    <= `QSO_RST_WORD_LEN;
         lsb_word <= 1'b0;
      end else if (word_end) begin
         width    <= fn_width(res);
         lsb_word <= lsb_first;
      end
   end

   assign sel_idx = lsb_word ? (5'd16 - width + bit_cnt) : (5'd15 - bit_cnt);

   genvar g;
   for (g = 0; g < NUM_LANES; g++) begin : g_lane
      qso_word_t lane_word;
      qso_word_t next_word;
      logic      subject;

      always_comb begin
         next_word = pat[15:0];
         subject   = pat[16];
         unique case (test_mode)
            QSO_TM_OFF: next_word = {sample_data[g], 6'h00};
            QSO_TM_PN_LONG, QSO_TM_PN_SHORT: next_word = {pn_word, 6'h00};
            default: ;
         endcase
         if (test_mode == QSO_TM_OFF) begin
            subject = 1'b1;
         end
         if (test_mode == QSO_TM_PN_LONG || test_mode == QSO_TM_PN_SHORT) begin
            subject = 1'b1;
         end
         if (subject && twos_comp) begin
            next_word[15] = ~next_word[15];
         end
         if (out_invert) begin
            next_word = ~next_word;
         end
      end

      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            lane_word <= 16'h0000;
         end else if (word_end) begin
            lane_word <= next_word;
         end
      end

      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            lane_data[g] <= 1'b0;
         end else begin
            // stuffed zeros past the data bits
            lane_data[g] <= (bit_cnt < width) ? lane_word[sel_idx[3:0]] : 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------------------
   // link clocks
   // ---------------------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         bit_clock_out        <= 1'b0;
         word_frame_clock_out <= 1'b0;
      end else begin
         // toggles mid-bit, one cycle per two bits, five cycles per 10-bit word
         if (half) begin
            bit_clock_out <= ~bit_clock_out;
         end
         // high for the first half of a word
         word_frame_clock_out <= (bit_cnt < (word_len >> 1));
      end
   end

endmodule : qso_serial_out
`default_nettype wire

// *** qso_serial_out_asserts.sv ***
// port checker of the quad serial output block
`timescale 1ns/1ps
`default_nettype none
module qso_serial_out_chk #(
   parameter int NUM_LANES = 4
) (
   // clock and reset
   input wire logic                 clock,
   input wire logic                 reset_n,
   // configuration port
   input wire logic                 cfg_write,
   input wire logic [7:0]           cfg_addr,
   input wire logic [7:0]           cfg_wdata,
   input wire logic [7:0]           cfg_rdata,
   // link and controls
   input wire logic [NUM_LANES-1:0] lane_data,
   input wire logic                 bit_clock_out,
   input wire logic                 word_frame_clock_out,
   input wire logic                 low_swing_mode,
   input wire logic                 termination_boost,
   input wire logic                 low_rate_pll_en
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   a_bitclk_period: assert property ($changed(bit_clock_out) |=> $stable(bit_clock_out) ##1 $changed(bit_clock_out))
      else $error("bit clock period is not four clocks");
   a_bit_hold: assert property ($changed(lane_data) |=> $stable(lane_data))
      else $error("serial bit held less than two clocks");
   a_frame_align: assert property ($changed(word_frame_clock_out) |-> $stable(bit_clock_out) ##1 $changed(bit_clock_out))
      else $error("frame edge not aligned to bit start");
   a_frame_period: assert property ($rose(word_frame_clock_out) |-> ##1 (!$rose(word_frame_clock_out))[*8] ##[1:20] $rose(word_frame_clock_out))
      else $error("frame period out of range");
   a_frame_high: assert property ($rose(word_frame_clock_out) |-> word_frame_clock_out[*8])
      else $error("frame high too short");
   a_swing_set: assert property (cfg_write && cfg_addr == 8'h14 && cfg_wdata[3] |-> ##2 low_swing_mode)
      else $error("reduced swing not entered");
   a_term_set: assert property (cfg_write && cfg_addr == 8'h15 |-> ##2 termination_boost == $past(cfg_wdata[0], 2))
      else $error("termination boost not following setting");
   a_pll_set: assert property (cfg_write && cfg_addr == 8'h21 |-> ##2 low_rate_pll_en == $past(cfg_wdata[3], 2))
      else $error("low rate pll not following setting");
   a_user_readback: assert property (cfg_write && cfg_addr == 8'h19 ##1 !cfg_write && cfg_addr == 8'h19
                                     |=> cfg_rdata == $past(cfg_wdata, 2))
      else $error("user word register read back wrong");

   c_frame: cover property ($rose(word_frame_clock_out));
   c_term: cover property ($rose(termination_boost));
   c_swing: cover property ($rose(low_swing_mode));
endmodule : qso_serial_out_chk

bind qso_serial_out qso_serial_out_chk #(.NUM_LANES(NUM_LANES)) u_chk (
   .clock(clock), .reset_n(reset_n), .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
   .cfg_rdata(cfg_rdata), .lane_data(lane_data), .bit_clock_out(bit_clock_out),
   .word_frame_clock_out(word_frame_clock_out), .low_swing_mode(low_swing_mode),
   .termination_boost(termination_boost), .low_rate_pll_en(low_rate_pll_en));
`default_nettype wire

// *** qso_serial_out_bench.sv ***
// self-checking bench of the quad serial output block
`timescale 1ns/1ps
`default_nettype none
module qso_serial_out_bench;
   import qso_pkg::*;
   logic             clock, reset_n, cfg_write, drive_mode_strap_pin;
   logic [7:0]       cfg_addr, cfg_wdata, cfg_rdata;
   logic [3:0][9:0]  sample_data;
   logic [3:0]       lane_data;
   logic             bit_clock_out, word_frame_clock_out;
   logic             low_swing_mode, termination_boost, low_rate_pll_en;
   logic [3:0][15:0] rx_word;
   logic [15:0]      mixw [4];
   int               rx_bits, rx_count, err_total, n_compared;
   int               cycles = 0;

   qso_serial_out uut (.clock(clock), .reset_n(reset_n), .sample_data(sample_data), .cfg_write(cfg_write),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .drive_mode_strap_pin(drive_mode_strap_pin),
      .lane_data(lane_data), .bit_clock_out(bit_clock_out), .word_frame_clock_out(word_frame_clock_out),
      .low_swing_mode(low_swing_mode), .termination_boost(termination_boost), .low_rate_pll_en(low_rate_pll_en));
   qso_rx_model u_rx (.bit_clock_out(bit_clock_out), .word_frame_clock_out(word_frame_clock_out),
      .lane_data(lane_data), .rx_word(rx_word), .rx_bits(rx_bits), .rx_count(rx_count));

   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         report_and_stop();
      end
   end

   // ---------------------------------
   // shared tasks
   // ---------------------------------
   task report_and_stop;
      $display("mismatches %0d comparisons %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_write = 1'b1;
      @(negedge clock);
      cfg_write = 1'b0;
   endtask : wr

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      cfg_addr = a;
      @(negedge clock);
      chk({8'h00, cfg_rdata}, {8'h00, exp});
   endtask : rd_chk

   task next_word;
      int c;
      c = rx_count;
      for (int k = 0; k < 60 && rx_count == c; k++) @(negedge clock);
      if (rx_count == c) begin
         err_total++;
         $display("Error at %0t: no word received", $time);
      end
   endtask : next_word

   task lanes_eq(input logic [15:0] exp);
      for (int i = 0; i < 4; i++) chk(rx_word[i], exp);
   endtask : lanes_eq

   task set_mode(input logic [3:0] m);
      wr(8'h0d, {4'h0, m});
      next_word();
      next_word();
      next_word();
   endtask : set_mode

   task do_reset(input logic strap);
      drive_mode_strap_pin = strap;
      reset_n = 1'b0;
      repeat (4) @(negedge clock);
      reset_n = 1'b1;
      repeat (6) @(negedge clock);
   endtask : do_reset

   // ---------------------------------
   // scenarios
   // ---------------------------------
   task t_regs;
      chk({13'h0, termination_boost, low_rate_pll_en, low_swing_mode}, 16'h0);
      for (int a = 8'h19; a <= 8'h1c; a++) rd_chk(8'(a), 8'h00);
      for (int a = 8'h19; a <= 8'h1c; a++) begin
         wr(8'(a), 8'h5a ^ 8'(a * 8'h25));
         rd_chk(8'(a), 8'h5a ^ 8'(a * 8'h25));
      end
      rd_chk(8'h3f, 8'h00);
   endtask : t_regs

   task t_normal;
      sample_data = {10'h1ff, 10'h000, 10'h200, 10'h3ff};
      set_mode(4'h0);
      for (int i = 0; i < 4; i++) chk(rx_word[i], {6'h0, sample_data[i]});
      chk(16'(rx_bits), 16'd10);
      wr(8'h14, 8'h01);
      next_word();
      next_word();
      next_word();
      for (int i = 0; i < 4; i++) chk(rx_word[i], {6'h0, sample_data[i] ^ 10'h200});
      set_mode(4'h2);
      lanes_eq(16'h1ff);
      set_mode(4'hc);
      lanes_eq(16'h263);
      wr(8'h14, 8'h00);
   endtask : t_normal

   task t_const;
      logic [3:0]  m [7];
      logic [15:0] e [7];
      m = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hc};
      e = '{16'h200, 16'h3ff, 16'h000, 16'h2aa, 16'h01f, 16'h200, 16'h263};
      for (int k = 0; k < 7; k++) begin
         set_mode(m[k]);
         lanes_eq(e[k]);
      end
      wr(8'h14, 8'h04);
      set_mode(4'hc);
      lanes_eq(16'h263 ^ 16'h3ff);
      wr(8'h14, 8'h00);
   endtask : t_const

   task t_alt(input logic [3:0] m, input logic [15:0] a, input logic [15:0] b);
      set_mode(m);
      if (rx_word[0] !== a) next_word();
      lanes_eq(a);
      next_word();
      lanes_eq(b);
   endtask : t_alt

   task t_res;
      int w, l;
      for (int r = 1; r < 4; r++) begin
         w = (r == 1) ? 8 : (r == 2) ? 12 : 14;
         l = (r == 1) ? 8 : 14;
         wr(8'h21, 8'(r));
         set_mode(4'ha);
         lanes_eq(16'(((1 << (w / 2)) - 1) << (l - w)));
         chk(16'(rx_bits), 16'(l));
         set_mode(4'hc);
         lanes_eq(16'(mixw[r] << (l - w)));
      end
      wr(8'h21, 8'h00);
   endtask : t_res

   task t_lsb;
      logic [15:0] e;
      e = 16'h0;
      for (int k = 0; k < 10; k++) e[k] = mixw[0][9 - k];
      wr(8'h21, 8'h80);
      set_mode(4'hc);
      lanes_eq(e);
      wr(8'h21, 8'h00);
   endtask : t_lsb

   task t_pn(input logic [3:0] m, input logic [15:0] s0, input logic [15:0] s1, input logic [15:0] s2);
      set_mode(m);
      for (int k = 0; k < 6 && rx_word[0] !== s0; k++) next_word();
      lanes_eq(s0);
      next_word();
      lanes_eq(s1);
      next_word();
      lanes_eq(s2);
   endtask : t_pn

   task t_drive;
      wr(8'h15, 8'h01);
      wr(8'h21, 8'h08);
      wr(8'h14, 8'h08);
      repeat (2) @(negedge clock);
      chk({13'h0, termination_boost, low_rate_pll_en, low_swing_mode}, 16'h7);
      wr(8'h15, 8'h00);
      wr(8'h21, 8'h00);
      wr(8'h14, 8'h00);
      repeat (2) @(negedge clock);
      chk({13'h0, termination_boost, low_rate_pll_en, low_swing_mode}, 16'h0);
   endtask : t_drive

   task t_strap;
      do_reset(1'b1);
      cfg_addr = 8'h22;
      @(negedge clock);
      chk({14'h0, cfg_rdata[0], low_swing_mode}, 16'h3);
      do_reset(1'b0);
      chk({15'h0, low_swing_mode}, 16'h0);
   endtask : t_strap

   initial begin
      clock = 1'b0;
      cfg_write = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
      sample_data = '0;
      err_total = 0;
      n_compared = 0;
      mixw = '{16'h0263, 16'h00a3, 16'h0a33, 16'h2867};
      do_reset(1'b0);
      t_regs();
      t_normal();
      t_const();
      t_alt(4'h4, 16'h2aa, 16'h155);
      t_alt(4'h7, 16'h3ff, 16'h000);
      t_alt(4'h8, 16'hc798 >> 6, 16'hbd56 >> 6);
      t_res();
      t_lsb();
      t_pn(4'h6, 16'h37e, 16'h135, 16'h0cc);
      t_pn(4'h5, 16'h359, 16'h07f, 16'h170);
      t_drive();
      t_strap();
      report_and_stop();
   end
endmodule : qso_serial_out_bench
`default_nettype wire
